// ### core/sde_core.sv
// two voice activity detectors and the acoustic echo comparator
//
// Overview of operation
// [R01] levels under the input floor, referenced to full scale, are not used
// [R02] level passes compander, spike filter, peak, then average and compare
// [R03] spike filter has a programmable constant, shorter than peak noise
// [R04] peak decay uses speech constant in speech, noise constant else
// [R05] average rises slowly in speech and fades fast in noise
// [R06] speech needs peak at least the offset above the average
// [R07] each detector gives one speech or no-speech bit
// [R08] average never charges above the cap over the input floor
// [R09] steady tones turn to no-speech unless above cap plus offset
// [R10] software should not program an endless rising average constant
// [R11] two equal detectors, transmit and receive, own parameter sets
// [R12] echo flag shows transmit level stronger than receive level
// [R13] transmit request needs echo flag and transmit speech together
// [R14] characteristic shaped by compensation gain, delta gain, decay slope
// [R15] only transmit above the characteristic changes the flag; the code also clears it when transmit speech is absent
// [R16] delta gain and decay slope each have speech and noise values
// [R17] speech set stays for the hold time after speech ends
// [R18] one update per sample, log arithmetic, cleared on reset
// [R19] peak follows rises at once, decays by the selected constant
`timescale 1ns/1ps
module sde_core (
  input logic clk,                          // sample clock, 100 MHz
  input logic sys_rst,                      // synchronous reset
  input sde_pkg::sde_pair_t sample,         // transmit and receive pcm
  input logic sample_valid,                 // sample pair offered
  output logic sample_ready,                // fifo has room
  input sde_pkg::sde_vad_cfg_t tx_cfg,      // transmit detector set
  input sde_pkg::sde_vad_cfg_t rx_cfg,      // receive detector set
  input sde_pkg::sde_echo_cfg_t echo_cfg,   // echo comparator set
  output logic tx_speech,                   // transmit speech found
  output logic rx_speech,                   // receive speech found
  output logic echo_flag,                   // transmit over echo line
  output logic echo_speech_set,             // speech coefficients used
  output logic transmit_request             // switch toward transmit
);
  import sde_pkg::*;

  sde_pair_t fifo_data;
  sde_pair_t pair;
  sde_phase_t phase;
  logic fifo_valid;
  logic [LVL_W-1:0] tx_lvl;
  logic [LVL_W-1:0] rx_lvl;
  logic [LVL_W-1:0] tx_peak;
  logic [LVL_W-1:0] rx_peak;
  logic echo_upd;
  logic [ACC_W-1:0] env;
  logic [15:0] hold_cnt;

  ////////////////////////////////////////////////////////////////////////
  // sample fifo: the three-phase pipeline drains at most one pair per
  // three clocks, so a source faster than that sees ready fall
  wire take = phase == PH_POP;

  sde_fifo #(
    .WIDTH($bits(sde_pair_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_data(sample),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(take)
  );

  ////////////////////////////////////////////////////////////////////////
  // logarithmic compander: octave from the leading one, four bits below
  // a 0.376 dB step keeps every later level on an eight-bit code
  function automatic logic [LVL_W-1:0] log_level(
    input logic [PCM_W-1:0] s
  );
    logic [PCM_W-1:0] mag;
    logic [PCM_W-1:0] norm;
    logic [3:0] oct;
    mag = s[PCM_W-1] ? PCM_W'(-s) : s;
    oct = 4'h0;
    for (int i = 1; i < PCM_W; i++) begin
      if (mag[i]) begin
        oct = 4'(i);
      end
    end
    norm = mag << (4'hF - oct);
    return (mag == '0) ? LVL_ZERO : {oct, norm[14:11]};
  endfunction : log_level

  ////////////////////////////////////////////////////////////////////////
  // phase sequence: pop a pair, compand it, strobe the detectors
  wire upd = phase == PH_FILT; // R18

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase <= PH_POP;
    end else begin
      unique case (phase)
        PH_POP: if (fifo_valid) phase <= PH_LOG;
        PH_LOG: phase <= PH_FILT;
        PH_FILT: phase <= PH_POP;
        default: phase <= PH_POP;
      endcase
    end
  end

  // sample and level registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pair <= '0;
      tx_lvl <= LVL_ZERO;
      rx_lvl <= LVL_ZERO;
      echo_upd <= 1'b0;
    end else begin
      if (take && fifo_valid) pair <= fifo_data;
      if (phase == PH_LOG) begin
        tx_lvl <= log_level(pair.tx); // R02
        rx_lvl <= log_level(pair.rx);
      end
      echo_upd <= upd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two identical detectors with separate sets
  sde_vad u_tx_vad ( // R11
    .clk(clk),
    .sys_rst(sys_rst),
    .upd(upd),
    .level(tx_lvl),
    .cfg(tx_cfg),
    .speech(tx_speech),
    .peak_level(tx_peak)
  );

  sde_vad u_rx_vad ( // R11
    .clk(clk),
    .sys_rst(sys_rst),
    .upd(upd),
    .level(rx_lvl),
    .cfg(rx_cfg),
    .speech(rx_speech),
    .peak_level(rx_peak)
  );

  ////////////////////////////////////////////////////////////////////////
  // coefficient set: speech values while receive speech or hold runs
  // hold counts samples, not clocks, so it follows the sample rate
  wire hold_run = hold_cnt != HOLD_RST;
  wire use_speech = rx_speech || hold_run; // R16 R17
  wire [LVL_W-1:0] delta = use_speech ? echo_cfg.echo_delta_gain_speech
                                      : echo_cfg.echo_delta_gain_noise;
  wire [FRAC_W-1:0] slope = use_speech
    ? echo_cfg.echo_decay_slope_speech
    : echo_cfg.echo_decay_slope_noise; // R16

  // receive level plus signed compensation gain, clipped to the range
  wire [LVL_W+1:0] gain_sum = {2'b00, rx_peak}
    + {{2{echo_cfg.echo_compensation_gain[LVL_W-1]}},
       echo_cfg.echo_compensation_gain}; // R14
  wire [LVL_W-1:0] rx_comp = gain_sum[LVL_W+1] ? LVL_ZERO
    : (gain_sum[LVL_W] ? LVL_TOP : gain_sum[LVL_W-1:0]);

  // characteristic: holds the echo peak, then falls by the slope
  wire [ACC_W-1:0] comp_acc = {rx_comp, FRAC_ZERO};
  wire env_attack = comp_acc >= env;
  wire [ACC_W-1:0] slope_acc = {LVL_ZERO, slope};
  wire [ACC_W-1:0] env_fall = (env > slope_acc) ? env - slope_acc
                                               : ACC_RST;
  wire [ACC_W-1:0] next_env = env_attack ? comp_acc : env_fall; // R14

  // delta gain lifts the line; transmit must lie strictly above it
  wire [LVL_W:0] char_lvl = {1'b0, next_env[ACC_W-1:FRAC_W]}
                          + {1'b0, delta}; // R14
  wire tx_above = {1'b0, tx_peak} > char_lvl; // R12 R15
  wire next_flag = tx_above || (echo_flag && tx_speech); // R15

  ////////////////////////////////////////////////////////////////////////
  // comparator state, updated once per sample after the detectors
  // one clock behind the strobe so it reads the fresh detector peaks
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      env <= ACC_RST; // R18
      echo_flag <= 1'b0;
      hold_cnt <= HOLD_RST;
      echo_speech_set <= 1'b0;
    end else if (echo_upd) begin
      env <= next_env;
      echo_flag <= next_flag; // R12
      echo_speech_set <= use_speech;
      if (rx_speech) begin
        hold_cnt <= echo_cfg.echo_hold_time; // R17
      end else if (hold_run) begin
        hold_cnt <= hold_cnt - 16'h0001; // R17
      end
    end
  end

  // the mode control only switches to transmit when both indications agree
  // registered so the attenuation side sees a clean level
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      transmit_request <= 1'b0;
    end else begin
      transmit_request <= echo_flag && tx_speech; // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // slope steps in accumulator units, for the checks below
  wire [ACC_W-1:0] speech_step =
    {LVL_ZERO, echo_cfg.echo_decay_slope_speech};
  wire [ACC_W-1:0] noise_step =
    {LVL_ZERO, echo_cfg.echo_decay_slope_noise};

  // the request only follows both indications
  chk_xmit_needs_both: assert property ( // R13
    transmit_request |-> $past(echo_flag) && $past(tx_speech))
    else $error("transmit request without flag and speech");

  // either indication missing drops the request
  chk_xmit_drops: assert property ( // R13
    !echo_flag || !tx_speech |=> !transmit_request)
    else $error("transmit request kept without both indications");

  // three phases per sample, so strobes never bunch up
  chk_sample_rate: assert property ( // R18
    upd |=> !upd [*2])
    else $error("detectors strobed twice in one sample");

  // detectors read levels made one clock before
  chk_log_before_upd: assert property ( // R02
    upd |-> $past(phase == PH_LOG))
    else $error("detectors strobed before the levels were ready");

  // a popped pair goes to the compander
  chk_pop_starts: assert property ( // R18
    take && fifo_valid |=> phase == PH_LOG && pair == $past(fifo_data))
    else $error("popped pair not latched for the compander");

  // echo under the line leaves the flag alone while transmit speech lasts
  chk_echo_no_change: assert property ( // R15
    echo_upd && !tx_above && tx_speech |=> $stable(echo_flag))
    else $error("echo level changed the comparator");

  // no transmit speech and not above: flag drops
  chk_flag_clears: assert property ( // R15
    echo_upd && !tx_above && !tx_speech |=> !echo_flag)
    else $error("echo flag kept without transmit speech");

  // a stronger transmit level always sets the flag
  chk_above_sets: assert property ( // R12
    echo_upd && tx_above |=> echo_flag)
    else $error("stronger transmit did not set the flag");

  // the hold keeps the speech set selected
  chk_hold_speech_set: assert property ( // R17
    echo_upd && hold_run |=> echo_speech_set)
    else $error("noise set used during echo hold");

  // receive speech reloads the full hold time
  chk_hold_reload: assert property ( // R17
    echo_upd && rx_speech |=> hold_cnt == $past(echo_cfg.echo_hold_time))
    else $error("hold time not reloaded during receive speech");

  // no speech and no hold: the noise set takes over
  chk_noise_set: assert property ( // R16
    echo_upd && !rx_speech && !hold_run |=> !echo_speech_set)
    else $error("speech set used after the hold ran out");

  // the line climbs to the compensated receive peak
  chk_env_attack: assert property ( // R14
    echo_upd && env_attack |=> env[ACC_W-1:FRAC_W] == $past(rx_comp))
    else $error("characteristic missed the echo peak");

  // the fall uses the slope of the set in force
  chk_slope_speech: assert property ( // R16
    echo_upd && !env_attack && use_speech && env > speech_step
      |=> $past(env) - env == $past(speech_step))
    else $error("characteristic fell by the wrong speech slope");
  chk_slope_noise: assert property ( // R16
    echo_upd && !env_attack && !use_speech && env > noise_step
      |=> $past(env) - env == $past(noise_step))
    else $error("characteristic fell by the wrong noise slope");

  // full fifo only while a source keeps offering
  chk_fifo_stall: assert property ( // R18
    !sample_ready |-> !$past(take && fifo_valid) || $past(sample_valid))
    else $error("fifo reported full with no source");

  // reset clears both speech indications and the echo flag within one clock
  chk_reset_clear: assert property ( // R18
    disable iff (1'b0) sys_rst |=> !tx_speech && !rx_speech && !echo_flag)
    else $error("state not cleared by reset");

  // the main scenarios a run should reach
  cov_tx_speech: cover property ($rose(tx_speech));
  cov_transmit: cover property ($rose(transmit_request));
  cov_echo_flag: cover property ($rose(echo_flag));
  cov_fifo_full: cover property (!sample_ready);
  cov_hold_noise: cover property ($fell(echo_speech_set));

endmodule : sde_core

// ### core/sde_fifo.sv
// sample fifo with registered full and empty flags
`timescale 1ns/1ps
module sde_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input logic clk,                 // sample clock
  input logic sys_rst,             // synchronous reset
  input logic [WIDTH-1:0] in_data, // word to store
  input logic in_valid,            // word offered
  output logic in_ready,           // room for a word
  output logic [WIDTH-1:0] out_data, // oldest word
  output logic out_valid,          // a word is held
  input logic out_ready            // consumer takes the word
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [AW:0] count;

  // handshakes and occupancy
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data = mem[rd_idx];

  ////////////////////////////////////////////////////////////////////////
  // flags are registered so the ready seen outside is glitch free
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wr_idx <= wr_idx + AW'(push);
      rd_idx <= rd_idx + AW'(pop);
      count <= next_count;
      in_ready <= next_count != CNT_FULL;
      out_valid <= next_count != '0;
    end
  end

  // storage needs no reset, it is never read while empty
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_idx] <= in_data;
    end
  end

endmodule : sde_fifo

// ### core/sde_pkg.sv
// shared constants and types for the speech detector and echo comparator
package sde_pkg;

  localparam int PCM_W = 16;
  localparam int LVL_W = 8;
  localparam int FRAC_W = 16;
  localparam int ACC_W = LVL_W + FRAC_W;
  localparam int FIFO_DEPTH = 8;

  // level code: 4 bit octave, 4 bit fraction, one step about 0.376 dB
  // full-scale pcm (+3.14 dB reference) maps to code F0
  localparam logic [LVL_W-1:0] LVL_FULL = 8'hF0;
  localparam logic [LVL_W-1:0] LVL_TOP = 8'hFF;
  localparam logic [LVL_W-1:0] LVL_ZERO = 8'h00;
  localparam logic [FRAC_W-1:0] FRAC_ZERO = 16'h0000;
  localparam logic [ACC_W-1:0] ACC_RST = 24'h000000;
  localparam logic [15:0] HOLD_RST = 16'h0000;

  // typical settings at 8 kHz sample rate; time constants are shifts
  localparam logic [LVL_W-1:0] TYP_FLOOR = 8'h60;   // 54 dB below full
  localparam logic [3:0] TYP_SPIKE_TC = 4'h5;       // 4 ms
  localparam logic [3:0] TYP_PEAK_SPEECH_TC = 4'hA; // 128 ms
  localparam logic [3:0] TYP_PEAK_NOISE_TC = 4'h8;  // 32 ms
  localparam logic [4:0] TYP_AVG_SPEECH_TC = 5'h10; // 8.2 s
  localparam logic [4:0] TYP_AVG_NOISE_TC = 5'h08;  // 32 ms
  localparam logic [LVL_W-1:0] TYP_CAP = 8'h42;     // 25 dB
  localparam logic [LVL_W-1:0] TYP_OFFSET = 8'h0C;  // 4.5 dB
  localparam logic [LVL_W-1:0] TYP_DELTA = 8'h10;   // 6 dB
  localparam logic [FRAC_W-1:0] TYP_SLOPE = 16'h0A03; // 8.5 ms/dB

  typedef struct packed {
    logic [LVL_W-1:0] input_floor_threshold;
    logic [3:0] spike_filter_tc;
    logic [3:0] peak_speech_tc;
    logic [3:0] peak_noise_tc;
    logic [4:0] average_speech_tc;
    logic [4:0] average_noise_tc;
    logic [LVL_W-1:0] average_charge_cap;
    logic [LVL_W-1:0] speech_offset;
  } sde_vad_cfg_t;

  typedef struct packed {
    logic [LVL_W-1:0] echo_compensation_gain; // two's complement
    logic [LVL_W-1:0] echo_delta_gain_speech;
    logic [LVL_W-1:0] echo_delta_gain_noise;
    logic [FRAC_W-1:0] echo_decay_slope_speech;
    logic [FRAC_W-1:0] echo_decay_slope_noise;
    logic [15:0] echo_hold_time;              // in samples
  } sde_echo_cfg_t;

  typedef struct packed {
    logic [PCM_W-1:0] tx;
    logic [PCM_W-1:0] rx;
  } sde_pair_t;

  typedef enum logic [1:0] {
    PH_POP = 2'b00,
    PH_LOG = 2'b01,
    PH_FILT = 2'b11
  } sde_phase_t;

  // one first-order step in the log domain: cur + (tgt - cur) / 2^k
  function automatic logic [ACC_W-1:0] sde_step(
    input logic [ACC_W-1:0] cur,
    input logic [ACC_W-1:0] tgt,
    input logic [4:0] k
  );
    logic signed [ACC_W:0] diff;
    diff = $signed({1'b0, tgt}) - $signed({1'b0, cur});
    diff = diff >>> k;
    return cur + diff[ACC_W-1:0];
  endfunction : sde_step

endpackage : sde_pkg

// ### core/sde_vad.sv
// one voice activity detector: compander level to speech flag
`timescale 1ns/1ps
module sde_vad (
  input logic clk,                            // sample clock
  input logic sys_rst,                        // synchronous reset
  input logic upd,                            // one pulse per sample
  input logic [sde_pkg::LVL_W-1:0] level,     // companded level
  input sde_pkg::sde_vad_cfg_t cfg,           // programmed set
  output logic speech,                        // speech found
  output logic [sde_pkg::LVL_W-1:0] peak_level // envelope level
);
  import sde_pkg::*;

  logic [ACC_W-1:0] spike;
  logic [ACC_W-1:0] peak;
  logic [ACC_W-1:0] avg;

  ////////////////////////////////////////////////////////////////////////
  // quiet samples sit at the floor so they carry no information
  wire below_floor = level < cfg.input_floor_threshold;
  wire [LVL_W-1:0] lvl_in =
    below_floor ? cfg.input_floor_threshold : level; // R01
  wire [ACC_W-1:0] in_acc = {lvl_in, FRAC_ZERO};

  // compander, spike filter, peak, average in one chain
  wire [ACC_W-1:0] next_spike =
    sde_step(spike, in_acc, {1'b0, cfg.spike_filter_tc}); // R02 R03
  wire attack = next_spike >= peak;
  wire [4:0] peak_k = speech ? {1'b0, cfg.peak_speech_tc}
                             : {1'b0, cfg.peak_noise_tc}; // R04
  wire [ACC_W-1:0] next_peak =
    attack ? next_spike : sde_step(peak, next_spike, peak_k); // R19

  // a huge speech shift stalls the average; software keeps it finite
  wire [4:0] avg_k = speech ? cfg.average_speech_tc
                            : cfg.average_noise_tc; // R05 R10
  wire [ACC_W-1:0] avg_raw = sde_step(avg, next_peak, avg_k); // R02

  // charge cap above the floor, saturating at the code range
  wire [LVL_W:0] cap_sum = {1'b0, cfg.input_floor_threshold}
                         + {1'b0, cfg.average_charge_cap};
  wire [LVL_W-1:0] cap_lvl = cap_sum[LVL_W] ? LVL_TOP
                                            : cap_sum[LVL_W-1:0];
  wire [ACC_W-1:0] cap_acc = {cap_lvl, FRAC_ZERO};
  wire [ACC_W-1:0] next_avg =
    (avg_raw > cap_acc) ? cap_acc : avg_raw; // R08

  // steady tones charge the average until they fall under the offset
  wire [LVL_W:0] thr = {1'b0, next_avg[ACC_W-1:FRAC_W]}
                     + {1'b0, cfg.speech_offset};
  wire next_speech =
    {1'b0, next_peak[ACC_W-1:FRAC_W]} >= thr; // R06 R09
  assign peak_level = peak[ACC_W-1:FRAC_W];

  ////////////////////////////////////////////////////////////////////////
  // state moves only on the sample strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      spike <= ACC_RST; // R18
      peak <= ACC_RST;
      avg <= ACC_RST;
      speech <= 1'b0;
    end else if (upd) begin
      spike <= next_spike;
      peak <= next_peak;
      avg <= next_avg;
      speech <= next_speech; // R07
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_peak_attack: assert property ( // R19
    upd && attack |=> peak == $past(next_spike))
    else $error("peak did not follow a rising input");
  chk_avg_capped: assert property ( // R08
    upd |=> avg <= {$past(cap_lvl), FRAC_ZERO})
    else $error("average charged above the cap");
  chk_speech_offset: assert property ( // R06
    $rose(speech) |-> {1'b0, peak[ACC_W-1:FRAC_W]} >=
      {1'b0, avg[ACC_W-1:FRAC_W]} + {1'b0, $past(cfg.speech_offset)})
    else $error("speech without peak over average plus offset");
  chk_quiet_hold: assert property ( // R18
    !upd |=> $stable(peak) && $stable(avg) && $stable(speech))
    else $error("detector moved without a sample");

endmodule : sde_vad

// ### testbench/sde_atten_model.sv
// behavioural attenuation control unit that follows the speakerphone mode
`timescale 1ns/1ps
module sde_atten_model (
  input logic clk,              // sample clock
  input logic sys_rst,          // synchronous reset
  input logic tx_speech,        // transmit speech found
  input logic rx_speech,        // receive speech found
  input logic transmit_request, // switch toward transmit
  output logic [1:0] mode       // 0 idle, 1 receive, 2 transmit
);
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_RX = 2'h1;
  localparam logic [1:0] MODE_TX = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // transmit is won only through the request; receive is never given up
  // to transmit speech alone, so echo in the microphone cannot steal it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode <= MODE_IDLE;
    end else if (transmit_request) begin
      mode <= MODE_TX;
    end else if (rx_speech && mode != MODE_TX) begin
      mode <= MODE_RX;
    end else if (!tx_speech && !rx_speech) begin
      mode <= MODE_IDLE;
    end
  end
endmodule : sde_atten_model

// ### testbench/sde_core_bench.sv
// self-checking bench for the speech detectors and echo comparator
`timescale 1ns/1ps
module sde_core_bench;
  import sde_pkg::*;
  logic clk;
  logic sys_rst;
  sde_pair_t sample;
  logic sample_valid;
  logic sample_ready;
  sde_vad_cfg_t tx_cfg;
  sde_vad_cfg_t rx_cfg;
  sde_echo_cfg_t echo_cfg;
  logic tx_speech, rx_speech, echo_flag, echo_speech_set, transmit_request;
  logic [1:0] mode;
  logic prev_req;
  logic prev_rst;
  logic found;
  int fail_count;
  int check_count;

  sde_core u_sde_core (.clk(clk), .sys_rst(sys_rst), .sample(sample),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .tx_cfg(tx_cfg), .rx_cfg(rx_cfg), .echo_cfg(echo_cfg),
    .tx_speech(tx_speech), .rx_speech(rx_speech), .echo_flag(echo_flag),
    .echo_speech_set(echo_speech_set),
    .transmit_request(transmit_request));
  sde_atten_model u_sde_atten_model (.clk(clk), .sys_rst(sys_rst),
    .tx_speech(tx_speech), .rx_speech(rx_speech),
    .transmit_request(transmit_request), .mode(mode));

  ////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // the request must trail echo flag and transmit speech by one clock
  always @(posedge clk) begin
    if (!sys_rst && !prev_rst) check(transmit_request, prev_req);
    prev_req <= echo_flag && tx_speech;
    prev_rst <= sys_rst;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
  endtask : do_reset

  // offer one pair and hold it until the edge where ready was high
  task automatic push(input logic [15:0] tx, input logic [15:0] rx);
    logic r;
    sample <= {tx, rx};
    sample_valid <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(negedge clk);
      r = sample_ready;
      @(posedge clk);
      if (r === 1'b1) return;
    end
    fail_count++;
    give_verdict();
  endtask : push

  // fifo of 8 pairs at 3 clocks each plus the output pipeline
  task automatic stop();
    sample_valid <= 1'b0;
    repeat (30) @(posedge clk);
  endtask : stop

  function automatic logic pick(input int sel);
    case (sel)
      0: pick = tx_speech;
      1: pick = rx_speech;
      2: pick = echo_flag;
      default: pick = echo_speech_set;
    endcase
  endfunction : pick

  // stream one pair until the chosen output shows val, bounded
  task automatic wait_for(input logic [15:0] tx, input logic [15:0] rx,
                          input int sel, input logic val, input int max);
    found = 1'b0;
    for (int i = 0; i < max; i++) begin
      push(tx, rx);
      if (pick(sel) === val) begin
        found = 1'b1;
        break;
      end
    end
  endtask : wait_for

  // silence lets the averages settle on the floor with no speech
  task automatic prime();
    repeat (100) push(16'h0000, 16'h0000);
    wait_for(16'h0000, 16'h0000, 0, 1'b0, 2000);
    check(found, 1'b1);
    wait_for(16'h0000, 16'h0000, 1, 1'b0, 2000);
    check(found, 1'b1);
    repeat (300) push(16'h0000, 16'h0000);
    check({tx_speech, rx_speech}, 2'h0);
  endtask : prime

  // finite rising constant keeps the average tracking the floor
  function automatic sde_vad_cfg_t vad(input logic [7:0] cap,
                                       input logic [7:0] off);
    vad = '{8'h60, 4'h1, 4'h3, 4'h2, 5'h08, 5'h04, cap, off};
  endfunction : vad

  ////////////////////////////////////////////////////////////////////////
  task automatic t_detect();
    do_reset();
    check(sample_ready, 1'b1);
    check({tx_speech, rx_speech, echo_flag, echo_speech_set,
           transmit_request}, 5'h00);
    prime();
    wait_for(16'h0010, 16'h0000, 0, 1'b1, 60);
    check(found, 1'b0);
    wait_for(16'h4000, 16'h0000, 0, 1'b1, 60);
    check(found, 1'b1);
    check(rx_speech, 1'b0);
    stop();
    do_reset();
    prime();
    wait_for(16'h0000, 16'h4000, 1, 1'b1, 60);
    check(found, 1'b1);
    check(tx_speech, 1'b0);
    stop();
    tx_cfg = vad(8'h42, 8'h90);
    do_reset();
    prime();
    wait_for(16'h4000, 16'h0000, 0, 1'b1, 60);
    check(found, 1'b0);
    stop();
    $display("test detect done");
  endtask : t_detect

  // steady tones: uncapped average charges up, the cap keeps speech
  task automatic t_tone();
    tx_cfg = vad(8'hFF, 8'h0C);
    do_reset();
    prime();
    wait_for(16'h0100, 16'h0000, 0, 1'b1, 40);
    check(found, 1'b1);
    wait_for(16'h0100, 16'h0000, 0, 1'b0, 1500);
    check(found, 1'b1);
    stop();
    tx_cfg = vad(8'h42, 8'h0C);
    do_reset();
    prime();
    wait_for(16'h4000, 16'h0000, 0, 1'b1, 40);
    check(found, 1'b1);
    wait_for(16'h4000, 16'h0000, 0, 1'b0, 1500);
    check(found, 1'b0);
    stop();
    $display("test tone done");
  endtask : t_tone

  // rx level, gain, delta, expected flag; equal levels count as echo
  task automatic t_echo();
    logic [39:0] tab [4] = '{{16'h0000, 8'h00, 8'h10, 8'h01},
      {16'h4000, 8'h00, 8'h10, 8'h00}, {16'h4000, 8'h00, 8'h00, 8'h00},
      {16'h4000, 8'hD0, 8'h10, 8'h01}};
    for (int i = 0; i < 4; i++) begin
      echo_cfg.echo_compensation_gain = tab[i][23:16];
      echo_cfg.echo_delta_gain_speech = tab[i][15:8];
      echo_cfg.echo_delta_gain_noise = tab[i][15:8];
      do_reset();
      prime();
      wait_for(16'h4000, tab[i][39:24], 2, 1'b1, 60);
      check(found, tab[i][0]);
      stop();
      check(tx_speech, 1'b1);
      check(transmit_request, tab[i][0]);
      check(mode == 2'h2, tab[i][0]);
    end
    $display("test echo done");
  endtask : t_echo

  // speech set holds 30 samples after receive speech ends
  task automatic t_hold();
    do_reset();
    prime();
    wait_for(16'h0000, 16'h4000, 3, 1'b1, 60);
    check(found, 1'b1);
    wait_for(16'h0000, 16'h0000, 1, 1'b0, 2000);
    check(found, 1'b1);
    repeat (10) push(16'h0000, 16'h0000);
    check(echo_speech_set, 1'b1);
    wait_for(16'h0000, 16'h0000, 3, 1'b0, 60);
    check(found, 1'b1);
    stop();
    $display("test hold done");
  endtask : t_hold

  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    sample = '0;
    sample_valid = 1'b0;
    prev_req = 1'b0;
    prev_rst = 1'b1;
    found = 1'b0;
    fail_count = 0;
    check_count = 0;
    tx_cfg = vad(8'h42, 8'h0C);
    rx_cfg = vad(8'h42, 8'h0C);
    // unequal slopes so the set in force shows in the characteristic
    echo_cfg = '{8'h00, 8'h10, 8'h10, 16'h0A03, 16'h1400, 16'h001E};
    t_detect();
    t_tone();
    tx_cfg = vad(8'h42, 8'h0C);
    t_echo();
    t_hold();
    give_verdict();
  end
endmodule : sde_core_bench
